// ===== bbg_pkg.sv
/*
 bbg_pkg: shared constants and types for the backplane bus glue.
 assumes: one 50 MHz clock domain; every pin input is indexed into one synchroniser vector.
*/
package bbg_pkg;
	// ==========================================================
	// clock and timing
	localparam int CLK_PERIOD_NS   = 20;
	localparam int SAMPLE_POINT_NS = 60;
	localparam int SAMPLE_CYCLES   = (SAMPLE_POINT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SAMPLE_CNT_W    = 3;

	// ==========================================================
	// interrupt controllers
	localparam int                    PIC_LINES          = 8;
	localparam logic [2:0]            CASCADE_INPUT      = 3'h2;
	localparam logic [2:0]            SPURIOUS_LINE      = 3'h7;
	localparam logic [7:0]            MASTER_VECTOR_BASE = 8'h08;
	localparam logic [7:0]            SLAVE_VECTOR_BASE  = 8'h70;
	localparam int                    HEADER_LINES       = 5;

	// ==========================================================
	// pin inputs passing the synchroniser
	localparam int PIN_BP_A     = 0;
	localparam int PIN_BP_B     = 1;
	localparam int PIN_BP_C     = 2;
	localparam int PIN_HDR_LO   = 3;
	localparam int PIN_DISK     = 8;
	localparam int PIN_VIDEO    = 9;
	localparam int PIN_MEM_WIDE = 10;
	localparam int PIN_IO_WIDE  = 11;
	localparam int PIN_SUPPLY   = 12;
	localparam int PIN_ROUTE_BP = 13;
	localparam int PIN_EXP_EN   = 14;
	localparam int PIN_COUNT    = 15;
	localparam logic [PIN_COUNT-1:0] PIN_RESET = 15'h1fff;

	// ==========================================================
	// on-board interrupt sources
	localparam int BRD_TIMER    = 0;
	localparam int BRD_KEYBOARD = 1;
	localparam int BRD_COM2     = 2;
	localparam int BRD_COM1     = 3;
	localparam int BRD_FIXED    = 4;
	localparam int BRD_FLOPPY   = 5;
	localparam int BRD_PRINTER  = 6;
	localparam int BRD_RTC      = 7;
	localparam int BRD_COPROC   = 8;
	localparam int BRD_COUNT    = 9;

	// ==========================================================
	// i/o decode
	localparam int             IO_ADDR_W = 10;
	localparam logic [9:0]     EXP_LOW   = 10'h100;
	localparam logic [9:0]     EXP_HIGH  = 10'h1ff;

	// ==========================================================
	// transfer width sequencer
	typedef enum logic [1:0] {
		WS_IDLE = 2'b00,
		WS_WAIT = 2'b01,
		WS_HOLD = 2'b10
	} bbg_width_state_t;
endpackage : bbg_pkg

// ===== bbg_pic_if.sv
/*
 bbg_pic_if: carrier between the glue top and one interrupt controller.
 assumes: requests are active-high levels on sys_clk; ack and eoi are one-cycle pulses.
*/
`timescale 1ns/10ps
interface bbg_pic_if;
	logic [7:0] req;
	logic [7:0] mask;
	logic       ack;
	logic       eoi;
	logic       intOut;
	logic [2:0] top;

	modport pic
	(
		input  req,
		input  mask,
		input  ack,
		input  eoi,
		output intOut,
		output top
	);

	modport ctl
	(
		output req,
		output mask,
		output ack,
		output eoi,
		input  intOut,
		input  top
	);
endinterface : bbg_pic_if

// ===== bbg_pic.sv
/*
 bbg_pic: one eight-input prioritised, maskable interrupt controller.
 assumes: line 0 is highest priority; ack sets the in-service bit of the current winner,
 eoi clears the highest-priority in-service bit.
*/
`timescale 1ns/10ps
module bbg_pic
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// controller port
	bbg_pic_if.pic   bus
);
	logic [7:0] inService;
	logic [7:0] pending;
	logic [2:0] next_top;
	logic       next_found;
	logic       blocked;
	logic [7:0] eoiClear;
	logic       eoiDone;

	// ==========================================================
	// priority resolve
	assign pending = bus.req & ~bus.mask;

	// a line under service masks itself and everything below it
	always_comb
	begin
		next_top   = 3'h0;
		next_found = 1'b0;
		blocked    = 1'b0;
		for (int i = 0; i < 8; i++)
		begin
			if (!next_found && !blocked)
			begin
				if (inService[i])
					blocked = 1'b1;
				else if (pending[i])
				begin
					next_found = 1'b1;
					next_top   = i[2:0];
				end
			end
		end
	end

	assign bus.intOut = next_found;
	assign bus.top    = next_top;

	// ==========================================================
	// in-service bookkeeping
	always_comb
	begin
		eoiClear = 8'h00;
		eoiDone  = 1'b0;
		for (int i = 0; i < 8; i++)
		begin
			if (!eoiDone && inService[i])
			begin
				eoiClear[i] = 1'b1;
				eoiDone     = 1'b1;
			end
		end
	end

	// set wins over clear when ack and eoi meet
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			inService <= 8'h00;
		else
		begin
			inService <= (inService & ~(bus.eoi ? eoiClear : 8'h00))
				| ((bus.ack && next_found) ? (8'h01 << next_top) : 8'h00);
		end
	end
endmodule : bbg_pic

// ===== bbg_glue.sv
/*
 bbg_glue: backplane bus glue between the processor side and the backplane.
 holds the interrupt routing into two cascaded controllers, transfer width selection,
 i/o expansion decode and supply-fault write blocking.
 assumes: cpu-side strobes are on sys_clk; backplane, header and jumper pins are asynchronous.
*/
// Operation
// RULE1: three backplane and five front-header interrupt lines reach the controllers.
// RULE2: two cascaded controllers, second one chained into master input two.
// RULE3: cascade resolution stays on board; no cascade address goes to backplane.
// RULE4: front disk and video lines go to their own fixed inputs.
// RULE5: input 5 shares fixed disk and backplane A; input 10 header and B.
// RULE6: jumper option routes video and disk over backplane lines instead.
// RULE7: low memory or i/o width acknowledge selects a sixteen-bit transfer.
// RULE8: both width acknowledges idle means an eight-bit transfer.
// RULE9: sixteen-bit cards drive their width acknowledge low; eight-bit cards leave it.
// RULE10: i/o 100 to 1ff drives expansion select low when jumper enables it.
// RULE11: i/o decode uses ten address bits.
// RULE12: general i/o cards should preferably sit within 100 to 1ff.
// RULE13: supply fault from the monitor asserts board reset.
// RULE14: write strobe held inactive while the supply fault lasts.
// RULE15: width acknowledges sampled once early; width held until cycle ends.
`timescale 1ns/10ps
module bbg_glue
(
	// clock and reset
	input  wire logic                          sys_clk,
	input  wire logic                          rst,
	// backplane interrupt pins
	input  wire logic                          backplane_irq_a_n,
	input  wire logic                          backplane_irq_b_n,
	input  wire logic                          backplane_irq_c_n,
	// front-plane interrupt pins
	input  wire logic [bbg_pkg::HEADER_LINES-1:0] headerIrq_n,
	input  wire logic                          diskIrq_n,
	input  wire logic                          videoIrq_n,
	// jumpers
	input  wire logic                          routeOverBackplane,
	input  wire logic                          expansionEnable,
	// on-board interrupt sources, active high
	input  wire logic [bbg_pkg::BRD_COUNT-1:0] boardIrq,
	input  wire logic [15:0]                   irqMask,
	// cpu interrupt handshake
	input  wire logic                          intAck,
	input  wire logic                          eoiMaster,
	input  wire logic                          eoiSlave,
	output logic                               cpuIntReq,
	output logic [7:0]                         intVector,
	output logic                               intVectorValid,
	// bus cycle and width
	input  wire logic                          cycleStart,
	input  wire logic                          cycleEnd,
	input  wire logic                          memCycle,
	input  wire logic                          mem_wide_ack_n,
	input  wire logic                          io_wide_ack_n,
	output logic                               transferWide,
	output logic                               widthValid,
	// i/o decode
	input  wire logic                          ioCycle,
	input  wire logic [bbg_pkg::IO_ADDR_W-1:0] ioAddr,
	output logic                               io_expansion_select_n,
	// supply supervision
	input  wire logic                          supplyFault_n,
	input  wire logic                          cpuWrite_n,
	output logic                               board_reset_n,
	output logic                               cpuWriteGated_n
);
	// ==========================================================
	// pin synchronisers
	logic [bbg_pkg::PIN_COUNT-1:0] pinRaw;
	logic [bbg_pkg::PIN_COUNT-1:0] syncA;
	logic [bbg_pkg::PIN_COUNT-1:0] syncB;
	logic [bbg_pkg::PIN_COUNT-1:0] syncC;
	logic [bbg_pkg::PIN_COUNT-1:0] pinStable;

	assign pinRaw[bbg_pkg::PIN_BP_A]     = backplane_irq_a_n;
	assign pinRaw[bbg_pkg::PIN_BP_B]     = backplane_irq_b_n;
	assign pinRaw[bbg_pkg::PIN_BP_C]     = backplane_irq_c_n;
	assign pinRaw[bbg_pkg::PIN_HDR_LO +: bbg_pkg::HEADER_LINES] = headerIrq_n;
	assign pinRaw[bbg_pkg::PIN_DISK]     = diskIrq_n;
	assign pinRaw[bbg_pkg::PIN_VIDEO]    = videoIrq_n;
	assign pinRaw[bbg_pkg::PIN_MEM_WIDE] = mem_wide_ack_n;
	assign pinRaw[bbg_pkg::PIN_IO_WIDE]  = io_wide_ack_n;
	assign pinRaw[bbg_pkg::PIN_SUPPLY]   = supplyFault_n;
	assign pinRaw[bbg_pkg::PIN_ROUTE_BP] = routeOverBackplane;
	assign pinRaw[bbg_pkg::PIN_EXP_EN]   = expansionEnable;

	// a change only counts once the second and third stage agree
	genvar g;
	generate
		for (g = 0; g < bbg_pkg::PIN_COUNT; g++)
		begin : gSync
			always_ff @(posedge sys_clk or posedge rst)
			begin
				if (rst)
				begin
					syncA[g]     <= bbg_pkg::PIN_RESET[g];
					syncB[g]     <= bbg_pkg::PIN_RESET[g];
					syncC[g]     <= bbg_pkg::PIN_RESET[g];
					pinStable[g] <= bbg_pkg::PIN_RESET[g];
				end
				else
				begin
					syncA[g] <= pinRaw[g];
					syncB[g] <= syncA[g];
					syncC[g] <= syncB[g];
					if (syncB[g] == syncC[g])
						pinStable[g] <= syncC[g];
				end
			end
		end
	endgenerate

	// ==========================================================
	// interrupt source routing
	logic                            bpA;
	logic                            bpB;
	logic                            bpC;
	logic [bbg_pkg::HEADER_LINES-1:0] hdr;
	logic                            frontDisk;
	logic                            frontVideo;
	logic                            routeBp;
	logic                            videoSel;
	logic                            hardDiskSel;

	// RULE1: backplane and header lines
	assign bpA = ~pinStable[bbg_pkg::PIN_BP_A];
	assign bpB = ~pinStable[bbg_pkg::PIN_BP_B];
	assign bpC = ~pinStable[bbg_pkg::PIN_BP_C];
	assign hdr = ~pinStable[bbg_pkg::PIN_HDR_LO +: bbg_pkg::HEADER_LINES];
	assign frontDisk  = ~pinStable[bbg_pkg::PIN_DISK];
	assign frontVideo = ~pinStable[bbg_pkg::PIN_VIDEO];
	assign routeBp    = pinStable[bbg_pkg::PIN_ROUTE_BP];

	// RULE6: backplane routing option
	assign videoSel    = routeBp ? bpB : frontVideo;
	assign hardDiskSel = routeBp ? bpA : frontDisk;

	bbg_pic_if masterBus ();
	bbg_pic_if slaveBus ();

	// RULE5: shared inputs five and ten
	// RULE4: dedicated disk and video inputs
	assign slaveBus.req = {
		hdr[3] | hdr[4],
		hardDiskSel,
		boardIrq[bbg_pkg::BRD_COPROC],
		hdr[2] | bpC,
		hdr[1],
		hdr[0] | bpB,
		videoSel,
		boardIrq[bbg_pkg::BRD_RTC]
	};

	// RULE2: slave output chained into master input two
	assign masterBus.req = {
		boardIrq[bbg_pkg::BRD_PRINTER],
		boardIrq[bbg_pkg::BRD_FLOPPY],
		boardIrq[bbg_pkg::BRD_FIXED] | bpA,
		boardIrq[bbg_pkg::BRD_COM1],
		boardIrq[bbg_pkg::BRD_COM2],
		slaveBus.intOut,
		boardIrq[bbg_pkg::BRD_KEYBOARD],
		boardIrq[bbg_pkg::BRD_TIMER]
	};

	assign masterBus.mask = irqMask[7:0];
	assign slaveBus.mask  = irqMask[15:8];
	assign masterBus.eoi  = eoiMaster;
	assign slaveBus.eoi   = eoiSlave;

	bbg_pic uMaster
	(
		.sys_clk (sys_clk),
		.rst     (rst),
		.bus     (masterBus.pic)
	);

	bbg_pic uSlave
	(
		.sys_clk (sys_clk),
		.rst     (rst),
		.bus     (slaveBus.pic)
	);

	// ==========================================================
	// acknowledge and vector
	logic cascadeHit;

	// RULE3: cascade resolved on board
	assign cascadeHit    = masterBus.intOut && (masterBus.top == bbg_pkg::CASCADE_INPUT);
	assign masterBus.ack = intAck;
	assign slaveBus.ack  = intAck && cascadeHit;

	// an ack with nothing pending answers with master line seven, the lowest priority
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			intVector      <= 8'h00;
			intVectorValid <= 1'b0;
		end
		else
		begin
			intVectorValid <= intAck;
			if (intAck)
			begin
				if (cascadeHit)
					intVector <= bbg_pkg::SLAVE_VECTOR_BASE | {5'h00, slaveBus.top};
				else if (masterBus.intOut)
					intVector <= bbg_pkg::MASTER_VECTOR_BASE | {5'h00, masterBus.top};
				else
					intVector <= bbg_pkg::MASTER_VECTOR_BASE | {5'h00, bbg_pkg::SPURIOUS_LINE};
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			cpuIntReq <= 1'b0;
		else
			cpuIntReq <= masterBus.intOut;
	end

	// ==========================================================
	// transfer width sequencer
	bbg_pkg::bbg_width_state_t         widthState;
	bbg_pkg::bbg_width_state_t         next_widthState;
	logic [bbg_pkg::SAMPLE_CNT_W-1:0]  sampleCount;
	logic                              cycleIsMem;
	logic                              samplePoint;
	logic                              wideAck;

	assign samplePoint = (widthState == bbg_pkg::WS_WAIT)
		&& (sampleCount == bbg_pkg::SAMPLE_CNT_W'(bbg_pkg::SAMPLE_CYCLES - 1));

	// RULE7: low acknowledge means sixteen bits
	// RULE8: idle acknowledges mean eight bits
	assign wideAck = cycleIsMem ? ~pinStable[bbg_pkg::PIN_MEM_WIDE]
		: ~pinStable[bbg_pkg::PIN_IO_WIDE];

	always_comb
	begin
		next_widthState = widthState;
		case (widthState)
			bbg_pkg::WS_IDLE:
				if (cycleStart)
					next_widthState = bbg_pkg::WS_WAIT;
			bbg_pkg::WS_WAIT:
				if (cycleEnd)
					next_widthState = bbg_pkg::WS_IDLE;
				else if (samplePoint)
					next_widthState = bbg_pkg::WS_HOLD;
			bbg_pkg::WS_HOLD:
				if (cycleEnd)
					next_widthState = bbg_pkg::WS_IDLE;
			default:
				next_widthState = bbg_pkg::WS_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			widthState <= bbg_pkg::WS_IDLE;
		else
			widthState <= next_widthState;
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			sampleCount <= '0;
			cycleIsMem  <= 1'b0;
		end
		else if (widthState == bbg_pkg::WS_IDLE && cycleStart)
		begin
			sampleCount <= '0;
			cycleIsMem  <= memCycle;
		end
		else if (widthState == bbg_pkg::WS_WAIT)
			sampleCount <= sampleCount + 1'b1;
	end

	// RULE15: one sample, held to cycle end
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			transferWide <= 1'b0;
			widthValid   <= 1'b0;
		end
		else if (samplePoint && !cycleEnd)
		begin
			transferWide <= wideAck;
			widthValid   <= 1'b1;
		end
		else if (cycleEnd)
		begin
			transferWide <= 1'b0;
			widthValid   <= 1'b0;
		end
	end

	// ==========================================================
	// i/o expansion decode
	logic expHit;

	// RULE11: ten-bit i/o decode
	// RULE10: expansion range select
	assign expHit = ioCycle && pinStable[bbg_pkg::PIN_EXP_EN]
		&& (ioAddr >= bbg_pkg::EXP_LOW) && (ioAddr <= bbg_pkg::EXP_HIGH);

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			io_expansion_select_n <= 1'b1;
		else
			io_expansion_select_n <= ~expHit;
	end

	// ==========================================================
	// supply supervision
	logic supplyFault;

	assign supplyFault = ~pinStable[bbg_pkg::PIN_SUPPLY];

	// RULE13: fault drives board reset
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			board_reset_n <= 1'b0;
		else
			board_reset_n <= ~supplyFault;
	end

	// RULE14: write blocked during fault
	// kept combinational so a healthy write is not delayed; reset also blocks writes
	assign cpuWriteGated_n = cpuWrite_n | supplyFault | rst;
endmodule : bbg_glue

// ===== bbg_glue_properties.sv
/*
 bbg_glue_properties: port timing checks for the backplane bus glue.
 assumes: bound to bbg_glue; one clock, asynchronous active-high reset.
*/
`timescale 1ns/10ps
module bbg_glue_properties
(
	// clock and reset
	input wire logic        sys_clk,
	input wire logic        rst,
	// interrupts
	input wire logic        intAck,
	input wire logic [7:0]  intVector,
	input wire logic        intVectorValid,
	input wire logic [15:0] irqMask,
	input wire logic        cpuIntReq,
	// width
	input wire logic        cycleStart,
	input wire logic        cycleEnd,
	input wire logic        memCycle,
	input wire logic        mem_wide_ack_n,
	input wire logic        io_wide_ack_n,
	input wire logic        transferWide,
	input wire logic        widthValid,
	// decode and supply
	input wire logic        ioCycle,
	input wire logic [9:0]  ioAddr,
	input wire logic        expansionEnable,
	input wire logic        io_expansion_select_n,
	input wire logic        supplyFault_n,
	input wire logic        cpuWrite_n,
	input wire logic        board_reset_n,
	input wire logic        cpuWriteGated_n
);
	// ==========================================================
	// pin stability, so the synchroniser delay is out of the way
	logic [2:0] memSt;
	logic [2:0] ioSt;
	logic [2:0] expSt;
	always_ff @(posedge sys_clk or posedge rst)
		if (rst)
			{memSt, ioSt, expSt} <= '0;
		else
		begin
			memSt <= $stable(mem_wide_ack_n) ? memSt + 3'(memSt != 3'h7) : 3'h0;
			ioSt  <= $stable(io_wide_ack_n) ? ioSt + 3'(ioSt != 3'h7) : 3'h0;
			expSt <= $stable(expansionEnable) ? expSt + 3'(expSt != 3'h7) : 3'h0;
		end

	// ==========================================================
	// assertions
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	AST_VECTOR_ANSWER: assert property (intAck |=> intVectorValid && intVector[7:3] inside {5'h01, 5'h0e})
		else $error("no vector one cycle after acknowledge");
	AST_VECTOR_ONLY_ON_ACK: assert property (!intAck |=> !intVectorValid)
		else $error("vector strobe without acknowledge");
	AST_MASKED_QUIET: assert property ((irqMask[7:0] == 8'hff) [*4] |-> !cpuIntReq)
		else $error("request raised with all lines masked");
	AST_WIDTH_LATENCY: assert property ($rose(widthValid) |-> $past(cycleStart, 4))
		else $error("width not sampled three cycles after start");
	AST_WIDTH_HOLD: assert property (widthValid && !cycleEnd |=> widthValid && $stable(transferWide))
		else $error("width changed inside the cycle");
	AST_WIDTH_END: assert property (widthValid && cycleEnd |=> !widthValid && !transferWide)
		else $error("width not dropped at cycle end");
	AST_MEM_WIDE: assert property ($rose(widthValid) && $past(memCycle, 4) && memSt == 3'h7
		|-> transferWide == !mem_wide_ack_n)
		else $error("memory width wrong");
	AST_IO_WIDE: assert property ($rose(widthValid) && !$past(memCycle, 4) && ioSt == 3'h7
		|-> transferWide == !io_wide_ack_n)
		else $error("io width wrong");
	AST_EXP_SELECT: assert property (expSt == 3'h7 && $stable(expansionEnable)
		|=> io_expansion_select_n == !$past(ioCycle && expansionEnable && ioAddr >= 10'h100 && ioAddr <= 10'h1ff))
		else $error("expansion select wrong");
	AST_EXP_TEN_BITS: assert property (ioAddr[9:8] != 2'b01 |=> io_expansion_select_n)
		else $error("expansion select outside range");
	AST_SUPPLY_RESET: assert property (!supplyFault_n [*8] |-> !board_reset_n)
		else $error("no board reset on supply fault");
	AST_WRITE_BLOCK: assert property (!supplyFault_n [*8] |-> cpuWriteGated_n)
		else $error("write passed during supply fault");
	AST_WRITE_PASS: assert property (supplyFault_n [*8] ##0 !cpuWrite_n |-> !cpuWriteGated_n)
		else $error("write blocked with good supply");
	cover property ($rose(widthValid) && transferWide);
	cover property (intVectorValid && intVector[7:3] == 5'h0e);
	cover property (!io_expansion_select_n);
	cover property ($fell(board_reset_n));
endmodule : bbg_glue_properties

bind bbg_glue bbg_glue_properties u_props
(
	.sys_clk(sys_clk), .rst(rst), .intAck(intAck), .intVector(intVector), .intVectorValid(intVectorValid),
	.irqMask(irqMask), .cpuIntReq(cpuIntReq), .cycleStart(cycleStart), .cycleEnd(cycleEnd),
	.memCycle(memCycle), .mem_wide_ack_n(mem_wide_ack_n), .io_wide_ack_n(io_wide_ack_n),
	.transferWide(transferWide), .widthValid(widthValid), .ioCycle(ioCycle), .ioAddr(ioAddr),
	.expansionEnable(expansionEnable), .io_expansion_select_n(io_expansion_select_n),
	.supplyFault_n(supplyFault_n), .cpuWrite_n(cpuWrite_n), .board_reset_n(board_reset_n),
	.cpuWriteGated_n(cpuWriteGated_n)
);

// ===== bbg_card_model.sv
/*
 bbg_card_model: backplane card answering width and raising interrupts.
 assumes: lines have pull-ups, so an undriven line reads high.
*/
`timescale 1ns/10ps
module bbg_card_model
(
	// bus side
	input wire logic       sys_clk,
	input wire logic       sel,
	input wire logic       memAccess,
	input wire logic       wide,
	input wire logic [1:0] lag,
	input wire logic [2:0] irqReq,
	// backplane pins
	output logic           mem_wide_ack_n,
	output logic           io_wide_ack_n,
	output logic           backplane_irq_a_n,
	output logic           backplane_irq_b_n,
	output logic           backplane_irq_c_n
);
	int selCnt = 0;
	// slow cards answer a few cycles after select
	always_ff @(posedge sys_clk)
		selCnt <= sel ? selCnt + 1 : 0;
	// wide card pulls its line low
	assign mem_wide_ack_n = !(sel && wide && memAccess && selCnt >= int'(lag));
	assign io_wide_ack_n  = !(sel && wide && !memAccess && selCnt >= int'(lag));
	assign {backplane_irq_c_n, backplane_irq_b_n, backplane_irq_a_n} = ~irqReq;
endmodule : bbg_card_model

// ===== backplane_bus_glue_test.sv
/*
 backplane_bus_glue_test: self-checking bench for bbg_glue.
 assumes: card model on the backplane; inputs change 1 ns after the edge.
*/
`timescale 1ns/10ps
module backplane_bus_glue_test;
	logic sys_clk = 1'b0, rst = 1'b1, sel = 1'b0, wide = 1'b0, memCycle = 1'b0, intAck = 1'b0;
	logic eoiMaster = 1'b0, eoiSlave = 1'b0, cycleStart = 1'b0, cycleEnd = 1'b0, ioCycle = 1'b0;
	logic diskIrq_n = 1'b1, videoIrq_n = 1'b1, routeOverBackplane = 1'b0, expansionEnable = 1'b0;
	logic supplyFault_n = 1'b1, cpuWrite_n = 1'b1;
	logic [1:0] lag = 2'h0;
	logic [2:0] bpReq = 3'h0;
	logic [4:0] headerIrq_n = 5'h1f;
	logic [8:0] boardIrq = 9'h000;
	logic [9:0] ioAddr = 10'h000;
	logic [15:0] irqMask = 16'hffff;
	logic [31:0] seed = 32'ha70b;
	logic cpuIntReq, intVectorValid, transferWide, widthValid, io_expansion_select_n;
	logic board_reset_n, cpuWriteGated_n, mem_wide_ack_n, io_wide_ack_n, bpA_n, bpB_n, bpC_n;
	logic [7:0] intVector;
	logic [7:0] vecQ[$];
	logic widthQ[$];
	logic lastValid = 1'b0;
	int mismatches = 0, compares = 0;
	int srcT[21] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 1, 0, 11, 12, 13, 14, 15, 16, 17, 18, 19};
	int lineT[21] = '{5, 10, 12, 10, 11, 12, 15, 15, 14, 9, 9, 14, 0, 1, 3, 4, 5, 6, 7, 8, 13};

	always #(bbg_pkg::CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;

	bbg_glue DUT (.sys_clk, .rst, .backplane_irq_a_n(bpA_n), .backplane_irq_b_n(bpB_n),
		.backplane_irq_c_n(bpC_n), .headerIrq_n, .diskIrq_n, .videoIrq_n, .routeOverBackplane,
		.expansionEnable, .boardIrq, .irqMask, .intAck, .eoiMaster, .eoiSlave, .cpuIntReq, .intVector,
		.intVectorValid, .cycleStart, .cycleEnd, .memCycle, .mem_wide_ack_n, .io_wide_ack_n,
		.transferWide, .widthValid, .ioCycle, .ioAddr, .io_expansion_select_n, .supplyFault_n,
		.cpuWrite_n, .board_reset_n, .cpuWriteGated_n);
	bbg_card_model CARD (.sys_clk, .sel, .memAccess(memCycle), .wide, .lag, .irqReq(bpReq),
		.mem_wide_ack_n, .io_wide_ack_n, .backplane_irq_a_n(bpA_n), .backplane_irq_b_n(bpB_n),
		.backplane_irq_c_n(bpC_n));

	// ==========================================================
	// helpers
	task automatic tick(input int n = 1);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : tick

	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task automatic finish_test();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : finish_test

	// bits 0-2 backplane, 3-7 header, 8 disk, 9 video, 11-19 on-board
	task automatic set_src(input logic [19:0] s);
		bpReq = s[2:0];
		headerIrq_n = ~s[7:3];
		diskIrq_n = ~s[8];
		videoIrq_n = ~s[9];
		boardIrq = s[19:11];
	endtask : set_src

	// ==========================================================
	// result monitor, oldest note first; falling edge so registered outputs have settled
	always @(negedge sys_clk)
	begin
		if (intVectorValid === 1'b1)
			check("intVector", intVector, vecQ.size() ? vecQ.pop_front() : 8'hxx);
		if (widthValid === 1'b1 && lastValid !== 1'b1)
			check("transferWide", 8'(transferWide), widthQ.size() ? 8'(widthQ.pop_front()) : 8'hxx);
		lastValid <= widthValid;
	end

	// ==========================================================
	// scenarios
	task automatic bus_cycle(input logic mem, input logic w, input logic abort);
		sel = 1'b1;
		memCycle = mem;
		wide = w;
		lag = seed[1:0];
		tick(8);
		if (!abort)
			widthQ.push_back(w);
		cycleStart = 1'b1;
		tick();
		cycleStart = 1'b0;
		if (!abort)
			repeat (10)
				if (widthValid !== 1'b1)
					tick();
		check("widthValid", 8'(widthValid), 8'(!abort));
		tick(2);
		cycleEnd = 1'b1;
		tick();
		cycleEnd = 1'b0;
		check("widthValid", 8'(widthValid), 8'h00);
		sel = 1'b0;
		tick(2);
	endtask : bus_cycle

	task automatic raise_irq(input int src, input logic route, input int line);
		logic [15:0] unm;
		unm = 16'h1 << line;
		unm[2] = unm[2] | (line > 7);
		irqMask = ~unm;
		routeOverBackplane = route;
		tick(6);
		set_src(20'h1 << src);
		repeat (12)
			if (cpuIntReq !== 1'b1)
				tick();
		check("cpuIntReq", 8'(cpuIntReq), 8'h01);
		// slave lines come back with the slave base, resolved on board
		vecQ.push_back(line < 8 ? bbg_pkg::MASTER_VECTOR_BASE | 8'(line) : bbg_pkg::SLAVE_VECTOR_BASE | 8'(line - 8));
		intAck = 1'b1;
		tick();
		intAck = 1'b0;
		set_src(20'h0);
		tick(6);
		eoiMaster = 1'b1;
		eoiSlave = line > 7;
		tick();
		{eoiMaster, eoiSlave} = 2'b00;
		tick();
	endtask : raise_irq

	initial
	begin
		#(bbg_pkg::CLK_PERIOD_NS * 20000);
		mismatches++;
		finish_test();
	end

	initial
	begin
		tick(3);
		rst = 1'b0;
		tick(6);
		check("board_reset_n", 8'(board_reset_n), 8'h01);
		for (int i = 0; i < 8; i++)
		begin
			seed = lfsr(seed);
			bus_cycle(i < 4 ? i[0] : seed[2], i < 4 ? i[1] : seed[3], i == 6);
		end
		for (int i = 0; i < 21; i++)
			raise_irq(srcT[i], i == 10 || i == 11, lineT[i]);
		vecQ.push_back(bbg_pkg::MASTER_VECTOR_BASE | 8'(bbg_pkg::SPURIOUS_LINE));
		intAck = 1'b1;
		tick();
		intAck = 1'b0;
		irqMask = 16'hffff;
		set_src(20'h1);
		tick(8);
		check("cpuIntReq", 8'(cpuIntReq), 8'h00);
		set_src(20'h0);
		expansionEnable = 1'b1;
		ioCycle = 1'b1;
		tick(6);
		for (int i = 0; i < 14; i++)
		begin
			seed = lfsr(seed);
			ioAddr = {i[0] ? 2'b01 : seed[9:8], seed[7:0]};
			if (i < 4)
				ioAddr = i[1] ? (i[0] ? 10'h1ff : 10'h200) : (i[0] ? 10'h100 : 10'h0ff);
			expansionEnable = i < 10;
			tick(i == 10 ? 6 : 1);
			check("io_expansion_select_n", 8'(io_expansion_select_n), 8'(!(expansionEnable &&
				ioAddr >= bbg_pkg::EXP_LOW && ioAddr <= bbg_pkg::EXP_HIGH)));
		end
		ioCycle = 1'b0;
		cpuWrite_n = 1'b0;
		tick();
		check("cpuWriteGated_n", 8'(cpuWriteGated_n), 8'h00);
		supplyFault_n = 1'b0;
		tick(8);
		check("board_reset_n", 8'(board_reset_n), 8'h00);
		check("cpuWriteGated_n", 8'(cpuWriteGated_n), 8'h01);
		supplyFault_n = 1'b1;
		tick(8);
		check("board_reset_n", 8'(board_reset_n), 8'h01);
		check("cpuWriteGated_n", 8'(cpuWriteGated_n), 8'h00);
		cpuWrite_n = 1'b1;
		tick(4);
		check("vecQ", 8'(vecQ.size()), 8'h00);
		check("widthQ", 8'(widthQ.size()), 8'h00);
		finish_test();
	end
endmodule : backplane_bus_glue_test
